// >>> hdl/wis_regs.vh
// wis_regs.vh: offsets, fields, defaults and timing of the settings block
// assumes a 40 MHz sys_clk and a 32-bit AXI4-Lite register port
`ifndef WIS_REGS_VH
`define WIS_REGS_VH
`define WIS_CLK_HZ     40000000
`define WIS_BAUD_1200  1200
`define WIS_BAUD_2400  2400
`define WIS_BAUD_4800  4800
`define WIS_BAUD_9600  9600
`define WIS_STILL_SEC  2
`define WIS_MIN_SEC    11'd60
// auto-off choices in minutes
`define WIS_OFF_M1     11'd3
`define WIS_OFF_M2     11'd5
`define WIS_OFF_M3     11'd10
`define WIS_OFF_M4     11'd20
`define WIS_OFF_M5     11'd30
// register byte offsets
`define WIS_OFS_CTRL   8'h00
`define WIS_OFS_IDENT  8'h04
`define WIS_OFS_FEED   8'h08
`define WIS_OFS_MENU   8'h0C
`define WIS_OFS_ZERO   8'h10
`define WIS_OFS_SPAN   8'h14
`define WIS_OFS_STAT   8'h18
// reset values and limits of control, ident and feed
`define WIS_CTRL_RST   32'h00000120
`define WIS_CTRL_MASK  32'h00077F7F
`define WIS_IDENT_RST  18'h1E240
`define WIS_IDENT_MAX  18'h30D3F
`define WIS_FEED_RST   7'h05
`define WIS_FEED_MAX   7'h63
// menu entry codes and the down bit
`define WIS_ENT_ZCAL   3'h1
`define WIS_ENT_SCAL   3'h2
`define WIS_ENT_VIEW   3'h3
`define WIS_ENT_DFLT   3'h6
`define WIS_ENT_SEG    3'h7
`define WIS_MENU_DOWN  8
// framing codes, line-end characters and AXI response codes
`define WIS_FR_8N      2'h0
`define WIS_FR_7O      2'h1
`define WIS_FR_7E      2'h2
`define WIS_CHAR_CR    8'h0D
`define WIS_CHAR_LF    8'h0A
`define WIS_RESP_OK    2'h0
`define WIS_RESP_ERR   2'h2
`endif

// >>> hdl/wis_top.v
// wis_top.v: weigh indicator settings, menu actions and serial sender
// assumes synchronous inputs and one-cycle pulses on the key inputs
`timescale 1ns/1ps
`include "wis_regs.vh"
module wis_top #(
  parameter SEC_CYCLES = `WIS_CLK_HZ,
  parameter SEG_CYCLES = `WIS_CLK_HZ,
  parameter WW         = 24
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst_n,
  // axi4-lite slave
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // scale side
  input  wire [WW-1:0] weight_value,
  input  wire          motion,
  input  wire          print_req,
  input  wire          unit_change_key,
  input  wire          key_activity,
  input  wire          zero_cal_done,
  input  wire          span_cal_done,
  input  wire [WW-1:0] cal_capture,
  // display and control
  output reg  [WW-1:0] display_weight,
  output reg  [2:0]    point_position,
  output reg  [1:0]    increment_select,
  output reg           unit_sel,
  output reg           segment_test,
  output reg           zero_cal_start,
  output reg           span_cal_start,
  output reg           cal_view_on,
  output reg           power_off,
  output reg           standstill,
  output reg           hold_active,
  // serial line
  output reg           txd
);

localparam TX_IDLE = 1'b0;
localparam TX_SHIFT = 1'b1;

////////////////////////////////////////////////////////////////////////
// register file
reg  [31:0]   ctrl;
reg  [17:0]   ident;
reg  [6:0]    feed;
reg  [2:0]    entry;
reg           restore_arm;
reg  [WW-1:0] zero_val;
reg  [WW-1:0] span_val;
reg           zero_ok;
reg           span_ok;
reg  [7:0]    wa;
reg  [31:0]   wd;
reg  [3:0]    ws;
reg           wa_ok;
reg           wd_ok;
reg  [31:0]   next_wr;
reg           do_restore;
reg  [31:0]   rd_mux;
reg           rd_hit;
reg           tx_busy;

wire          do_wr = wa_ok & wd_ok & ~s_axi_bvalid;
wire          down  = do_wr & (wa == `WIS_OFS_MENU) & ws[1]
                      & wd[`WIS_MENU_DOWN];

function [31:0] merge;
  input [31:0] old;
  input [31:0] nw;
  input [3:0]  st;
  integer      i;
  begin
    merge = old;
    for (i = 0; i < 4; i = i + 1)
      if (st[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  end
endfunction

always @* begin
  next_wr    = 32'h00000000;
  do_restore = down & (entry == `WIS_ENT_DFLT) & restore_arm;
  if (wa == `WIS_OFS_CTRL)
    next_wr = merge(ctrl, wd, ws);
  else if (wa == `WIS_OFS_IDENT)
    next_wr = merge({14'h0000, ident}, wd, ws);
  else if (wa == `WIS_OFS_FEED)
    next_wr = merge({25'h0000000, feed}, wd, ws);
  else if (wa == `WIS_OFS_ZERO)
    next_wr = merge({8'h00, zero_val}, wd, ws);
  else if (wa == `WIS_OFS_SPAN)
    next_wr = merge({8'h00, span_val}, wd, ws);
end

always @(posedge sys_clk) begin
  if (!rst_n) begin
    s_axi_awready <= 1'b0;
    s_axi_wready  <= 1'b0;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `WIS_RESP_OK;
    wa_ok <= 1'b0;
    wd_ok <= 1'b0;
    wa    <= 8'h00;
    wd    <= 32'h00000000;
    ws    <= 4'h0;
  end else begin
    s_axi_awready <= ~wa_ok & ~s_axi_awready & s_axi_awvalid;
    s_axi_wready  <= ~wd_ok & ~s_axi_wready & s_axi_wvalid;
    if (s_axi_awvalid & s_axi_awready) begin
      wa_ok <= 1'b1;
      wa    <= s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      wd_ok <= 1'b1;
      wd    <= s_axi_wdata;
      ws    <= s_axi_wstrb;
    end
    if (do_wr) begin
      wa_ok        <= 1'b0;
      wd_ok        <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wa[7:5] == 3'h0 && wa[1:0] == 2'h0 &&
                       wa != `WIS_OFS_STAT) ? `WIS_RESP_OK : `WIS_RESP_ERR;
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

// settings storage; restore wins over any write in the same cycle
always @(posedge sys_clk) begin
  if (!rst_n || do_restore) begin
    ctrl        <= `WIS_CTRL_RST;
    ident       <= `WIS_IDENT_RST;
    feed        <= `WIS_FEED_RST;
    entry       <= 3'h0;
    restore_arm <= 1'b0;
  end else if (do_wr) begin
    if (wa == `WIS_OFS_CTRL)
      ctrl <= next_wr & `WIS_CTRL_MASK;
    if (wa == `WIS_OFS_IDENT && next_wr <= {14'h0000, `WIS_IDENT_MAX})
      ident <= next_wr[17:0];
    if (wa == `WIS_OFS_FEED && next_wr <= {25'h0000000, `WIS_FEED_MAX})
      feed <= next_wr[6:0];
    if (wa == `WIS_OFS_MENU && ws[0]) begin
      entry       <= wd[2:0];
      restore_arm <= 1'b0;
    end
    if (down && entry == `WIS_ENT_DFLT)
      restore_arm <= 1'b1;
  end
end

// calibration store: captured or keyed-in values
always @(posedge sys_clk) begin
  if (!rst_n) begin
    zero_val <= {WW{1'b0}};
    span_val <= {WW{1'b0}};
    zero_ok  <= 1'b0;
    span_ok  <= 1'b0;
  end else begin
    if (zero_cal_done) begin
      zero_val <= cal_capture;
      zero_ok  <= 1'b1;
    end else if (do_wr && wa == `WIS_OFS_ZERO) begin
      zero_val <= next_wr[WW-1:0];
      zero_ok  <= 1'b1;
    end
    if (span_cal_done) begin
      span_val <= cal_capture;
      span_ok  <= 1'b1;
    end else if (do_wr && wa == `WIS_OFS_SPAN && next_wr[WW-1:0] != 0) begin
      span_val <= next_wr[WW-1:0]; // zero span refused
      span_ok  <= 1'b1;
    end
  end
end

always @* begin
  rd_hit = 1'b1;
  rd_mux = 32'h00000000;
  if (s_axi_araddr == `WIS_OFS_CTRL)
    rd_mux = ctrl;
  else if (s_axi_araddr == `WIS_OFS_IDENT)
    rd_mux = {14'h0000, ident};
  else if (s_axi_araddr == `WIS_OFS_FEED)
    rd_mux = {25'h0000000, feed};
  else if (s_axi_araddr == `WIS_OFS_MENU)
    rd_mux = {28'h0000000, restore_arm, entry};
  else if (s_axi_araddr == `WIS_OFS_ZERO)
    rd_mux = {8'h00, zero_val};
  else if (s_axi_araddr == `WIS_OFS_SPAN)
    rd_mux = {8'h00, span_val};
  else if (s_axi_araddr == `WIS_OFS_STAT)
    rd_mux = {25'h0000000, zero_ok & span_ok, segment_test, power_off,
              tx_busy, hold_active, standstill};
  else
    rd_hit = 1'b0;
end

always @(posedge sys_clk) begin
  if (!rst_n) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= 32'h00000000;
    s_axi_rresp   <= `WIS_RESP_OK;
  end else begin
    s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
    if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `WIS_RESP_OK : `WIS_RESP_ERR;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// menu actions, unit key, display settings
reg [31:0] seg_cnt;

always @(posedge sys_clk) begin
  if (!rst_n) begin
    zero_cal_start   <= 1'b0;
    span_cal_start   <= 1'b0;
    cal_view_on      <= 1'b0;
    segment_test     <= 1'b0;
    seg_cnt          <= 32'h00000000;
    unit_sel         <= 1'b0;
    point_position   <= 3'h0;
    increment_select <= 2'h0;
  end else begin
    zero_cal_start   <= down & (entry == `WIS_ENT_ZCAL);
    span_cal_start   <= down & (entry == `WIS_ENT_SCAL);
    point_position   <= ctrl[4:2];
    increment_select <= ctrl[1:0];
    if (down && entry == `WIS_ENT_VIEW)
      cal_view_on <= 1'b1;
    else if (do_wr && wa == `WIS_OFS_MENU)
      cal_view_on <= 1'b0;
    if (down && entry == `WIS_ENT_SEG) begin
      segment_test <= 1'b1;
      seg_cnt      <= SEG_CYCLES - 1;
    end else if (seg_cnt != 0)
      seg_cnt <= seg_cnt - 32'h00000001;
    else
      segment_test <= 1'b0;
    if (unit_change_key && ctrl[5])
      unit_sel <= ~unit_sel;
  end
end

////////////////////////////////////////////////////////////////////////
// standstill, hold and auto power-off
reg [31:0] still_cnt;
reg [31:0] sec_cnt;
reg [10:0] idle_sec;
reg [10:0] off_limit;
reg [WW-1:0] held;

always @* begin
  case (ctrl[18:16])
    3'h1:    off_limit = `WIS_OFF_M1 * `WIS_MIN_SEC;
    3'h2:    off_limit = `WIS_OFF_M2 * `WIS_MIN_SEC;
    3'h3:    off_limit = `WIS_OFF_M3 * `WIS_MIN_SEC;
    3'h4:    off_limit = `WIS_OFF_M4 * `WIS_MIN_SEC;
    3'h5:    off_limit = `WIS_OFF_M5 * `WIS_MIN_SEC;
    default: off_limit = 11'h000;
  endcase
end

always @(posedge sys_clk) begin
  if (!rst_n) begin
    still_cnt      <= 32'h00000000;
    standstill     <= 1'b0;
    hold_active    <= 1'b0;
    held           <= {WW{1'b0}};
    display_weight <= {WW{1'b0}};
    sec_cnt        <= 32'h00000000;
    idle_sec       <= 11'h000;
    power_off      <= 1'b0;
  end else begin
    if (motion) begin
      still_cnt  <= 32'h00000000;
      standstill <= 1'b0;
    end else if (still_cnt == `WIS_STILL_SEC * SEC_CYCLES - 1)
      standstill <= 1'b1;
    else
      still_cnt <= still_cnt + 32'h00000001;
    if (!ctrl[6])
      hold_active <= 1'b0;
    else if (!hold_active && standstill && weight_value != 0) begin
      hold_active <= 1'b1;
      held        <= weight_value;
    end else if (hold_active && {weight_value, 1'b0} <= {1'b0, held})
      hold_active <= 1'b0;
    display_weight <= hold_active ? held : weight_value;
    if (key_activity || motion || off_limit == 0) begin
      sec_cnt  <= 32'h00000000;
      idle_sec <= 11'h000;
    end else if (sec_cnt == SEC_CYCLES - 1) begin
      sec_cnt  <= 32'h00000000;
      idle_sec <= idle_sec + 11'h001;
    end else
      sec_cnt <= sec_cnt + 32'h00000001;
    if (off_limit != 0 && idle_sec >= off_limit)
      power_off <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// serial sender: message bytes and character shifter
reg        tx_st;
reg [9:0]  shreg;
reg [3:0]  bit_n;
reg [15:0] baud_cnt;
reg [15:0] baud_div;
reg [1:0]  frame_act;
reg [2:0]  msg_idx;
reg [6:0]  lf_left;
reg [7:0]  ch;
reg        par;
reg [23:0] wsnap;
reg        ticket;
wire       id_on = ctrl[13] & ctrl[14];

function [15:0] div_of;
  input [1:0] sel;
  integer     d;
  begin
    case (sel)
      2'h0:    d = `WIS_CLK_HZ / `WIS_BAUD_1200;
      2'h1:    d = `WIS_CLK_HZ / `WIS_BAUD_2400;
      2'h2:    d = `WIS_CLK_HZ / `WIS_BAUD_4800;
      default: d = `WIS_CLK_HZ / `WIS_BAUD_9600;
    endcase
    div_of = d[15:0];
  end
endfunction

always @* begin
  case (msg_idx)
    3'h0:    ch = {6'h00, ident[17:16]};
    3'h1:    ch = ident[15:8];
    3'h2:    ch = ident[7:0];
    3'h3:    ch = wsnap[23:16];
    3'h4:    ch = wsnap[15:8];
    3'h5:    ch = wsnap[7:0];
    3'h6:    ch = `WIS_CHAR_CR;
    default: ch = `WIS_CHAR_LF;
  endcase
  par = ^ch[6:0] ^ (ctrl[11:10] == `WIS_FR_7O);
end

always @(posedge sys_clk) begin
  if (!rst_n) begin
    tx_st     <= TX_IDLE;
    txd       <= 1'b1;
    shreg     <= 10'h3FF;
    bit_n     <= 4'h0;
    baud_cnt  <= 16'h0000;
    baud_div  <= 16'h0000;
    frame_act <= `WIS_FR_8N;
    tx_busy   <= 1'b0;
    msg_idx   <= 3'h0;
    lf_left   <= 7'h00;
    wsnap     <= 24'h000000;
    ticket    <= 1'b0;
  end else begin
    case (tx_st)
      TX_IDLE: begin
        txd <= 1'b1;
        if (!tx_busy && (ctrl[12] || (print_req && standstill))) begin
          tx_busy <= 1'b1;
          wsnap   <= display_weight;
          ticket  <= ctrl[13];
          lf_left <= ctrl[13] ? feed : 7'h00;
          msg_idx <= id_on ? 3'h0 : 3'h3;
        end else if (tx_busy) begin
          // baud and framing settings are sampled only here, never mid-character
          baud_div  <= div_of(ctrl[9:8]);
          frame_act <= ctrl[11:10];
          baud_cnt  <= 16'h0000;
          bit_n     <= 4'h0;
          tx_st     <= TX_SHIFT;
          if (ctrl[11:10] == `WIS_FR_8N)
            shreg <= {1'b1, ch, 1'b0};
          else if (ctrl[11:10] == `WIS_FR_7O ||
                   ctrl[11:10] == `WIS_FR_7E)
            shreg <= {1'b1, par, ch[6:0], 1'b0};
          else
            shreg <= {2'h3, ch[6:0], 1'b0};
        end
      end
      default: begin
        txd <= shreg[0];
        if (baud_cnt == baud_div - 16'h0001) begin
          baud_cnt <= 16'h0000;
          shreg    <= {1'b1, shreg[9:1]};
          bit_n    <= bit_n + 4'h1;
          if (bit_n == 4'h9) begin
            tx_st <= TX_IDLE;
            if (msg_idx == 3'h6 && ticket && lf_left != 0)
              msg_idx <= 3'h7;
            else if (msg_idx == 3'h7 && lf_left > 7'h01)
              lf_left <= lf_left - 7'h01;
            else if (msg_idx >= 3'h6)
              tx_busy <= 1'b0;
            else
              msg_idx <= msg_idx + 3'h1;
          end
        end else
          baud_cnt <= baud_cnt + 16'h0001;
      end
    endcase
  end
end

endmodule // wis_top

// >>> dv/wis_properties.sv
// wis_properties: port-level assertions for wis_top
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module wis_properties #(
  parameter SEC_CYCLES = 10,
  parameter SEG_CYCLES = 8,
  parameter WW         = 24
) (
  // clock and reset
  input wire          sys_clk,
  input wire          rst_n,
  // watched ports
  input wire          motion,
  input wire          unit_change_key,
  input wire [WW-1:0] display_weight,
  input wire          unit_sel,
  input wire          segment_test,
  input wire          zero_cal_start,
  input wire          span_cal_start,
  input wire          power_off,
  input wire          standstill,
  input wire          hold_active
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  // run lengths; 32 bits so a run never wraps
  reg [31:0] quiet;
  reg [31:0] seg_len;
  always @(posedge sys_clk) begin
    quiet <= (!rst_n || motion) ? 32'h0 : quiet + 32'h1;
    seg_len <= (!rst_n || !segment_test) ? 32'h0 : seg_len + 32'h1;
  end
  //////////////////////////////////////////////////////////////////////
  a_still_after_quiet: assert property (
    $rose(standstill) |-> quiet >= 2 * SEC_CYCLES - 1)
    else $error("standstill declared too early");
  a_motion_drops_still: assert property (
    motion |-> ##[1:2] !standstill)
    else $error("standstill kept during motion");
  a_power_sticky: assert property (
    power_off |=> power_off)
    else $error("power off released");
  a_zcal_pulse: assert property (
    zero_cal_start |=> !zero_cal_start)
    else $error("zero start longer than a cycle");
  a_scal_pulse: assert property (
    span_cal_start |=> !span_cal_start)
    else $error("span start longer than a cycle");
  a_hold_needs_still: assert property (
    $rose(hold_active) |-> standstill || $past(standstill))
    else $error("hold captured in motion");
  a_hold_freezes: assert property (
    hold_active && $past(hold_active) && $past(hold_active, 2)
      |-> $stable(display_weight))
    else $error("held weight moved");
  a_seg_length: assert property (
    $fell(segment_test) |-> seg_len == SEG_CYCLES)
    else $error("display test wrong length");
  a_unit_by_key: assert property (
    $rose(unit_sel) |-> $past(unit_change_key))
    else $error("unit changed without key");
endmodule // wis_properties

bind wis_top wis_properties #(
  .SEC_CYCLES(SEC_CYCLES), .SEG_CYCLES(SEG_CYCLES), .WW(WW)
) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .motion(motion),
  .unit_change_key(unit_change_key), .display_weight(display_weight),
  .unit_sel(unit_sel), .segment_test(segment_test),
  .zero_cal_start(zero_cal_start), .span_cal_start(span_cal_start),
  .power_off(power_off), .standstill(standstill),
  .hold_active(hold_active)
);

// >>> dv/wis_serial_rx.sv
// wis_serial_rx: far-side receiver, decodes one character at a time
// assumes idle-high txd and a bit time given in sys_clk cycles
`timescale 1ns/1ps
module wis_serial_rx (
  // clock and line
  input wire        sys_clk,
  input wire        txd,
  // framing choice
  input wire [15:0] bit_cycles,
  input wire        seven_bits,
  input wire        has_parity,
  // last character
  output reg  [7:0] rx_data,
  output reg        rx_par,
  output reg        rx_stop,
  output reg  [7:0] rx_count
);
  integer i;
  initial begin
    rx_data = 8'h00;
    rx_par = 1'b0;
    rx_stop = 1'b0;
    rx_count = 8'h00;
    forever begin
      @(negedge txd);
      // mid-bit sampling tolerates the rounded bit time
      repeat (bit_cycles / 2) @(posedge sys_clk);
      if (txd == 1'b0) begin
        rx_data = 8'h00;
        for (i = 0; i < (seven_bits ? 7 : 8); i = i + 1) begin
          repeat (bit_cycles) @(posedge sys_clk);
          rx_data[i] = txd;
        end
        if (has_parity) begin
          repeat (bit_cycles) @(posedge sys_clk);
          rx_par = txd;
        end
        repeat (bit_cycles) @(posedge sys_clk);
        rx_stop = txd;
        rx_count = rx_count + 8'h01;
      end
    end
  end
endmodule // wis_serial_rx

// >>> dv/tb_weigh_indicator_settings.sv
// tb_weigh_indicator_settings: self-checking bench of wis_top
// assumes wis_regs.vh on the include path and wis_serial_rx
`timescale 1ns/1ps
`include "wis_regs.vh"
module tb_weigh_indicator_settings;
  reg sys_clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  reg arv = 1'b0, rrdy = 1'b0, motion = 1'b0, preq = 1'b0, ukey = 1'b0;
  reg zdone = 1'b0, sdone = 1'b0, kact = 1'b0, rx_seven = 1'b1;
  reg rx_par_on = 1'b1;
  reg [15:0] rx_bits = 16'h1046;
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [23:0] weight = 24'h0, capture = 24'h0;
  wire awr, wr_rdy, bv, arr, rv, ssl, hold, z_go, s_go, view, seg, poff;
  wire still, txd, unit;
  wire [1:0] br, rr, incr;
  wire [2:0] pt;
  wire [31:0] rd_d;
  wire [23:0] disp;
  wire [7:0] rx_d, rx_n;
  wire rx_p, rx_s;
  wire [2:0] watch = {poff, seg, still};
  integer mismatches = 0, total_checks = 0, cycles = 0, n, i, nz = 0, ns = 0;
  reg [28:0] rows [0:5];
  always #12.5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////
  wis_top #(.SEC_CYCLES(10), .SEG_CYCLES(8), .WW(24)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .weight_value(weight), .motion(motion),
    .print_req(preq), .unit_change_key(ukey), .key_activity(kact),
    .zero_cal_done(zdone), .span_cal_done(sdone), .cal_capture(capture),
    .display_weight(disp), .point_position(pt), .increment_select(incr),
    .unit_sel(unit), .segment_test(seg), .zero_cal_start(z_go),
    .span_cal_start(s_go), .cal_view_on(view), .power_off(poff),
    .standstill(still), .hold_active(hold), .txd(txd));
  // 9600 baud, 7 bits with parity
  wis_serial_rx i_rx (.sys_clk(sys_clk), .txd(txd),
    .bit_cycles(rx_bits), .seven_bits(rx_seven), .has_parity(rx_par_on),
    .rx_data(rx_d), .rx_par(rx_p), .rx_stop(rx_s), .rx_count(rx_n));
  //////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg b;
    begin
      b = 1'b0;
      @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      while (!b) begin
        @(posedge sys_clk);
        if (awr) awv <= 1'b0;
        if (wr_rdy) wv <= 1'b0;
        if (bv) b = 1'b1;
      end
      brdy <= 1'b0;
      chk({30'h0, br}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg b;
    begin
      b = 1'b0;
      @(posedge sys_clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      while (!b) begin
        @(posedge sys_clk);
        if (arr) arv <= 1'b0;
        if (rv) b = 1'b1;
      end
      rrdy <= 1'b0;
      chk(rd_d, ed);
      chk({30'h0, rr}, {30'h0, er});
    end
  endtask
  // entry write, then a down press on it
  task menu(input [2:0] e);
    begin
      wr(`WIS_OFS_MENU, {29'h0, e}, 2'h0);
      wr(`WIS_OFS_MENU, {23'h0, 1'b1, 5'h0, e}, 2'h0);
    end
  endtask
  task wait_for(input integer s, input integer lim);
    begin
      n = 0;
      while (watch[s] !== 1'b1 && n < lim) begin
        @(posedge sys_clk);
        n = n + 1;
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (z_go) nz <= nz + 1;
    if (s_go) ns <= ns + 1;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  initial begin
    // control word, expected point, expected increment
    rows[0] = {24'h000000, 3'h0, 2'h0};
    rows[1] = {24'h000505, 3'h1, 2'h1};
    rows[2] = {24'h000A0A, 3'h2, 2'h2};
    rows[3] = {24'h000F0C, 3'h3, 2'h0};
    rows[4] = {24'h050011, 3'h4, 2'h1};
    rows[5] = {24'h000016, 3'h5, 2'h2};
    tick(3);
    rst_n <= 1'b1;
    rd(`WIS_OFS_CTRL, 32'h00000120, 2'h0);
    rd(`WIS_OFS_IDENT, 32'h0001E240, 2'h0);
    rd(`WIS_OFS_FEED, 32'h00000005, 2'h0);
    for (i = 0; i < 6; i = i + 1) begin
      wr(`WIS_OFS_CTRL, {8'h00, rows[i][28:5]}, 2'h0);
      rd(`WIS_OFS_CTRL, {8'h00, rows[i][28:5]}, 2'h0);
      chk({29'h0, pt}, {29'h0, rows[i][4:2]});
      chk({30'h0, incr}, {30'h0, rows[i][1:0]});
    end
    wr(`WIS_OFS_IDENT, 32'h00030D3F, 2'h0);
    wr(`WIS_OFS_IDENT, 32'h00030D40, 2'h0);
    rd(`WIS_OFS_IDENT, 32'h00030D3F, 2'h0);
    wr(`WIS_OFS_FEED, 32'h00000063, 2'h0);
    wr(`WIS_OFS_FEED, 32'h00000064, 2'h0);
    rd(`WIS_OFS_FEED, 32'h00000063, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(`WIS_OFS_STAT, 32'h0, 2'h2);
    ukey <= 1'b1;
    tick(1);
    ukey <= 1'b0;
    tick(3);
    chk({31'h0, unit}, 32'h0);
    wr(`WIS_OFS_CTRL, 32'h00000020, 2'h0);
    ukey <= 1'b1;
    tick(1);
    ukey <= 1'b0;
    tick(3);
    chk({31'h0, unit}, 32'h1);
    menu(3'h1);
    tick(1);
    chk(nz, 32'h1);
    menu(3'h2);
    tick(1);
    chk(ns, 32'h1);
    menu(3'h3);
    chk({31'h0, view}, 32'h1);
    menu(3'h7);
    wait_for(1, 20);
    chk({31'h0, seg}, 32'h1);
    tick(12);
    capture <= 24'h00BEEF;
    zdone <= 1'b1;
    tick(1);
    zdone <= 1'b0;
    rd(`WIS_OFS_ZERO, 32'h0000BEEF, 2'h0);
    capture <= 24'h00CAFE;
    sdone <= 1'b1;
    tick(1);
    sdone <= 1'b0;
    rd(`WIS_OFS_SPAN, 32'h0000CAFE, 2'h0);
    wr(`WIS_OFS_ZERO, 32'h0000ABCD, 2'h0);
    rd(`WIS_OFS_ZERO, 32'h0000ABCD, 2'h0);
    wr(`WIS_OFS_SPAN, 32'h00001234, 2'h0);
    wr(`WIS_OFS_SPAN, 32'h0, 2'h0);
    rd(`WIS_OFS_SPAN, 32'h00001234, 2'h0);
    wr(`WIS_OFS_IDENT, 32'h00000007, 2'h0);
    menu(3'h6);
    rd(`WIS_OFS_CTRL, 32'h00000020, 2'h0);
    wr(`WIS_OFS_MENU, 32'h00000106, 2'h0);
    rd(`WIS_OFS_CTRL, 32'h00000120, 2'h0);
    rd(`WIS_OFS_IDENT, 32'h0001E240, 2'h0);
    rd(`WIS_OFS_FEED, 32'h00000005, 2'h0);
    motion <= 1'b1;
    tick(3);
    motion <= 1'b0;
    wait_for(0, 100);
    chk({31'h0, n >= 19 && n <= 24}, 32'h1);
    wr(`WIS_OFS_CTRL, 32'h00000160, 2'h0);
    weight <= 24'h0003E8;
    tick(5);
    chk({31'h0, hold}, 32'h1);
    weight <= 24'h000258;
    tick(5);
    chk({8'h0, disp}, 32'h000003E8);
    motion <= 1'b1;
    weight <= 24'h0001F4;
    tick(5);
    chk({31'h0, hold}, 32'h0);
    chk({8'h0, disp}, 32'h000001F4);
    motion <= 1'b0;
    // 9600 baud, odd parity; first character only, to keep the run short
    wr(`WIS_OFS_CTRL, 32'h00000720, 2'h0);
    weight <= 24'hA53C0F;
    tick(40);
    chk({24'h0, rx_n}, 32'h0);
    rd(`WIS_OFS_STAT, 32'h00000021, 2'h0);
    preq <= 1'b1;
    tick(1);
    preq <= 1'b0;
    wr(`WIS_OFS_CTRL, 32'h00000320, 2'h0);
    while (rx_n == 8'h00) @(posedge sys_clk);
    chk({24'h0, rx_d}, 32'h00000025);
    chk({30'h0, rx_p, rx_s}, 32'h1);
    chk({31'h0, poff}, 32'h0);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    wr(`WIS_OFS_CTRL, 32'h00010120, 2'h0);
    // a key press halfway must restart the idle count
    tick(900);
    kact <= 1'b1;
    tick(1);
    kact <= 1'b0;
    wait_for(2, 3000);
    chk({31'h0, n >= 1780 && n <= 1815}, 32'h1);
    wr(`WIS_OFS_CTRL, 32'h00001120, 2'h0);
    rd(`WIS_OFS_STAT, 32'h0000000D, 2'h0);
    summarize;
  end
endmodule // tb_weigh_indicator_settings
